//--- crp_defs.svh
// register map, field layout and bus codes of the peak result bank
`ifndef CRP_DEFS_SVH
`define CRP_DEFS_SVH

`define CRP_ADDR_W        12
`define CRP_DATA_W        32
`define CRP_REG_W         16
`define CRP_IDX_W         10

// register indices; the byte address is four times the index
`define CRP_IDX_POS_D0_C4 10'h197
`define CRP_IDX_POS_D1_D2 10'h198
`define CRP_IDX_POS_D3_D4 10'h199
`define CRP_IDX_AMP_A0_A1 10'h19a
`define CRP_IDX_AMP_A2_A3 10'h19b
`define CRP_IDX_AMP_A4_B0 10'h19c
`define CRP_IDX_CTRL      10'h1c0
`define CRP_IDX_STATUS    10'h1c1

// field layout
`define CRP_POS_W         8
`define CRP_AMP_W         7
`define CRP_BANK_WORDS    6
`define CRP_FIRST_AMP     3'h3
`define CRP_CTRL_HOLD     0
`define CRP_STAT_CNT_LSB  8
`define CRP_CNT_W         8

// pairs and peak numbers
`define CRP_PAIR_A        2'h0
`define CRP_PAIR_B        2'h1
`define CRP_PAIR_C        2'h2
`define CRP_PAIR_D        2'h3
`define CRP_PEAK_FIFTH    3'h4

// axi responses
`define CRP_RESP_OKAY     2'h0
`define CRP_RESP_SLVERR   2'h2

`endif

//--- crp_field_bank.sv
// storage of the peak fields, updated only by the measuring engine
`timescale 1ns/1ps
`include "crp_defs.svh"

module crp_field_bank (
  // clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // engine update
  input  wire logic                upd_fire,
  input  wire crp_pkg::crp_kind_e  upd_kind,
  input  wire logic [1:0]          upd_pair,
  input  wire logic [2:0]          upd_peak,
  input  wire logic [7:0]          upd_value,
  // read port
  input  wire logic                rd_en,
  input  wire logic [2:0]          rd_slot,
  output crp_pkg::crp_word_t       rd_word
);

  logic [`CRP_BANK_WORDS-1:0][15:0] words_q;
  logic                             hit;
  logic [2:0]                       slot;
  logic                             hi;
  logic [7:0]                       field;
  crp_pkg::crp_word_t               rd_word_q;

  // ordinal n of the field in the bank: slot n/2, high byte when n is odd
  function automatic logic [4:0] place(input crp_pkg::crp_kind_e k,
                                       input logic [1:0] pr, input logic [2:0] pk);
    logic [3:0] n;
    logic       ok;
    n  = 4'h0;
    ok = 1'b0;
    if (k == crp_pkg::crp_kind_pos)
    begin
      if (pr == `CRP_PAIR_C && pk == `CRP_PEAK_FIFTH)
      begin
        ok = 1'b1;
      end
      else if (pr == `CRP_PAIR_D && pk <= `CRP_PEAK_FIFTH)
      begin
        ok = 1'b1;
        n  = {1'b0, pk} + 4'h1;
      end
    end
    else if (pr == `CRP_PAIR_A && pk <= `CRP_PEAK_FIFTH)
    begin
      ok = 1'b1;
      n  = {1'b0, pk} + {`CRP_FIRST_AMP, 1'b0};
    end
    else if (pr == `CRP_PAIR_B && pk == 3'h0)
    begin
      ok = 1'b1;
      n  = 4'hb;
    end
    return {ok, n[3:1], n[0]};
  endfunction : place

  assign {hit, slot, hi} = place(upd_kind, upd_pair, upd_peak);
  // amplitude keeps its top bit at zero so the reserved bit reads zero
  assign field = (upd_kind == crp_pkg::crp_kind_amp) ? {1'b0, upd_value[6:0]} : upd_value;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      words_q <= '0;
    else if (upd_fire && hit)
    begin
      if (hi)
        words_q[slot][15:8] <= field;
      else
        words_q[slot][7:0] <= field;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rd_word_q <= 16'h0;
    else if (rd_en)
      rd_word_q <= words_q[rd_slot];
  end

  assign rd_word = rd_word_q;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  property p_pos(logic [1:0] pr, logic [2:0] pk, int s, bit h);
    @(posedge aclk) disable iff (!aresetn)
    upd_fire && upd_kind == crp_pkg::crp_kind_pos && upd_pair == pr && upd_peak == pk
      |=> (h ? words_q[s][15:8] : words_q[s][7:0]) == $past(upd_value);
  endproperty

  property p_amp(logic [1:0] pr, logic [2:0] pk, int s, bit h);
    @(posedge aclk) disable iff (!aresetn)
    upd_fire && upd_kind == crp_pkg::crp_kind_amp && upd_pair == pr && upd_peak == pk
      |=> (h ? words_q[s][14:8] : words_q[s][6:0]) == $past(upd_value[6:0]);
  endproperty

  a_c_fifth_pos:   assert property (p_pos(`CRP_PAIR_C, 3'h4, 0, 1'b0))
    else $error("pair c fifth position misplaced");
  a_d_first_pos:   assert property (p_pos(`CRP_PAIR_D, 3'h0, 0, 1'b1))
    else $error("pair d first position misplaced");
  a_d_third_pos:   assert property (p_pos(`CRP_PAIR_D, 3'h2, 1, 1'b1))
    else $error("pair d third position misplaced");
  a_d_fourth_pos:  assert property (p_pos(`CRP_PAIR_D, 3'h3, 2, 1'b0))
    else $error("pair d fourth position misplaced");
  a_a_second_amp:  assert property (p_amp(`CRP_PAIR_A, 3'h1, 3, 1'b1))
    else $error("pair a second amplitude misplaced");
  a_a_third_amp:   assert property (p_amp(`CRP_PAIR_A, 3'h2, 4, 1'b0))
    else $error("pair a third amplitude misplaced");
  a_b_first_amp:   assert property (p_amp(`CRP_PAIR_B, 3'h0, 5, 1'b1))
    else $error("pair b first amplitude misplaced");

  // every stored position (pair c fifth, pair d first to fifth) lands whole in its byte
  a_pos_full_byte: assert property (@(posedge aclk) disable iff (!aresetn)
    upd_fire && hit && upd_kind == crp_pkg::crp_kind_pos
      |=> ($past(hi) ? words_q[$past(slot)][15:8] : words_q[$past(slot)][7:0])
        == $past(upd_value))
    else $error("position field lost bits");

  a_amp_reserved:  assert property (@(posedge aclk) disable iff (!aresetn)
    (words_q[3][15] | words_q[3][7] | words_q[4][15] | words_q[4][7]
     | words_q[5][15] | words_q[5][7]) == 1'b0)
    else $error("reserved amplitude bit set");

  a_only_engine:   assert property (@(posedge aclk) disable iff (!aresetn)
    !upd_fire |=> $stable(words_q))
    else $error("stored field changed without engine update");

endmodule : crp_field_bank

//--- crp_peak_results.sv
// top of the cable reflection peak result bank with its axi4-lite slave
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "crp_defs.svh"

module crp_peak_results (
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,

  // axi4-lite write address
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [`CRP_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]             s_axi_awprot,

  // axi4-lite write data
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  input  wire logic [`CRP_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,

  // axi4-lite write response
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  output logic [1:0]                  s_axi_bresp,

  // axi4-lite read address
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  input  wire logic [`CRP_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]             s_axi_arprot,

  // axi4-lite read data
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic [`CRP_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,

  // result updates from the measuring engine
  input  wire logic                   upd_valid,
  output logic                        upd_ready,
  input  wire crp_pkg::crp_kind_e     upd_kind,
  input  wire logic [1:0]             upd_pair,
  input  wire logic [2:0]             upd_peak,
  input  wire logic [7:0]             upd_value
);

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  function automatic crp_pkg::crp_idx_t idx_of(input logic [`CRP_ADDR_W-1:0] a);
    return a[`CRP_ADDR_W-1:2];
  endfunction : idx_of

  function automatic logic in_bank(input crp_pkg::crp_idx_t i);
    return (i >= `CRP_IDX_POS_D0_C4) && (i <= `CRP_IDX_AMP_A4_B0);
  endfunction : in_bank

  function automatic logic [2:0] slot_of(input crp_pkg::crp_idx_t i);
    crp_pkg::crp_idx_t d;
    d = i - `CRP_IDX_POS_D0_C4;
    return d[2:0];
  endfunction : slot_of

  function automatic logic is_local(input crp_pkg::crp_idx_t i);
    return (i == `CRP_IDX_CTRL) || (i == `CRP_IDX_STATUS);
  endfunction : is_local

  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic                     wr_fire;
  logic [`CRP_ADDR_W-1:0]   wr_addr;
  logic [`CRP_DATA_W-1:0]   wr_data;
  logic [3:0]               wr_strb;
  logic [1:0]               wr_resp;
  crp_pkg::crp_idx_t        wr_idx;

  crp_pkg::crp_rd_e         rd_state_q;
  crp_pkg::crp_rd_e         rd_state_d;
  crp_pkg::crp_idx_t        ar_idx;
  logic                     ar_fire;
  logic                     src_bank_q;
  logic [`CRP_DATA_W-1:0]   local_q;
  logic [1:0]               rresp_q;
  crp_pkg::crp_word_t       bank_word;

  logic                     hold_q;
  logic [`CRP_CNT_W-1:0]    upd_count_q;
  logic                     upd_fire;

  // ----------------------------------------------------------------------
  // write path
  // ----------------------------------------------------------------------
  crp_wr_path u_wr (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .awaddr  (s_axi_awaddr),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .bresp   (s_axi_bresp),
    .wr_fire (wr_fire),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_resp (wr_resp)
  );

  assign wr_idx = idx_of(wr_addr);

  // result registers accept the write and drop it, so drivers that
  // blindly write back a read-modify-write do not see errors
  always_comb
  begin
    if (is_local(wr_idx))
      wr_resp = `CRP_RESP_OKAY;
    else if (in_bank(wr_idx))
      wr_resp = `CRP_RESP_OKAY;
    else
      wr_resp = `CRP_RESP_SLVERR;
  end

  // ----------------------------------------------------------------------
  // control: hold freezes the results while software reads a set
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      hold_q <= 1'b0;
    else if (wr_fire && wr_idx == `CRP_IDX_CTRL && wr_strb[0])
      hold_q <= wr_data[`CRP_CTRL_HOLD];
  end

  // ----------------------------------------------------------------------
  // engine updates
  // ----------------------------------------------------------------------
  // the engine is stalled, not dropped, while hold is set
  assign upd_ready = !hold_q;
  assign upd_fire  = upd_valid && upd_ready;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      upd_count_q <= '0;
    else if (upd_fire)
      upd_count_q <= upd_count_q + 1'b1;
  end

  crp_field_bank u_bank (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .upd_fire  (upd_fire),
    .upd_kind  (upd_kind),
    .upd_pair  (upd_pair),
    .upd_peak  (upd_peak),
    .upd_value (upd_value),
    .rd_en     (ar_fire),
    .rd_slot   (slot_of(ar_idx)),
    .rd_word   (bank_word)
  );

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  assign ar_idx        = idx_of(s_axi_araddr);
  assign s_axi_arready = (rd_state_q == crp_pkg::crp_rd_idle);
  assign ar_fire       = s_axi_arvalid && s_axi_arready;

  always_comb
  begin
    rd_state_d = rd_state_q;
    case (rd_state_q)
      crp_pkg::crp_rd_idle:
        if (s_axi_arvalid)
          rd_state_d = crp_pkg::crp_rd_resp;
      crp_pkg::crp_rd_resp:
        if (s_axi_rready)
          rd_state_d = crp_pkg::crp_rd_idle;
      default:
        rd_state_d = crp_pkg::crp_rd_idle;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rd_state_q <= crp_pkg::crp_rd_idle;
    else
      rd_state_q <= rd_state_d;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      src_bank_q <= 1'b0;
      local_q    <= '0;
      rresp_q    <= `CRP_RESP_OKAY;
    end
    else if (ar_fire)
    begin
      src_bank_q <= in_bank(ar_idx);
      if (in_bank(ar_idx))
      begin
        local_q <= '0;
        rresp_q <= `CRP_RESP_OKAY;
      end
      else if (ar_idx == `CRP_IDX_CTRL)
      begin
        local_q <= '0;
        local_q[`CRP_CTRL_HOLD] <= hold_q;
        rresp_q <= `CRP_RESP_OKAY;
      end
      else if (ar_idx == `CRP_IDX_STATUS)
      begin
        local_q <= '0;
        local_q[`CRP_STAT_CNT_LSB +: `CRP_CNT_W] <= upd_count_q;
        local_q[`CRP_CTRL_HOLD] <= hold_q;
        rresp_q <= `CRP_RESP_OKAY;
      end
      else
      begin
        local_q <= '0;
        rresp_q <= `CRP_RESP_SLVERR;
      end
    end
  end

  // upper half of a result word always reads zero
  assign s_axi_rvalid = (rd_state_q == crp_pkg::crp_rd_resp);
  assign s_axi_rdata  = src_bank_q ? {16'h0, bank_word} : local_q;
  assign s_axi_rresp  = rresp_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  sequence s_r_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence

  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_ar_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not one cycle after address");

  a_read_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data changed before taken");

  a_read_unmapped: assert property (@(posedge aclk) disable iff (!aresetn)
    s_ar_taken ##0 (!in_bank(ar_idx) && !is_local(ar_idx))
      |=> s_axi_rresp == `CRP_RESP_SLVERR)
    else $error("unmapped read not refused");

  a_bank_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_ar_taken ##0 in_bank(ar_idx)
      |=> s_axi_rdata[31:16] == 16'h0 && (slot_of($past(ar_idx)) < `CRP_FIRST_AMP
      || (s_axi_rdata[15] == 1'b0 && s_axi_rdata[7] == 1'b0)))
    else $error("result read carries stray bits");

  a_hold_stalls: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && wr_idx == `CRP_IDX_CTRL && wr_strb[0] && wr_data[0]
      |=> !upd_ready)
    else $error("engine not stalled by hold");

  a_bank_write_ok: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && in_bank(wr_idx) |=> s_axi_bvalid && s_axi_bresp == `CRP_RESP_OKAY
      && $stable(hold_q))
    else $error("result write answered wrongly");

endmodule : crp_peak_results

//--- crp_peak_results_tb.sv
// self-checking bench of the peak result bank, driven over axi4-lite
`timescale 1ns/1ps
`include "crp_defs.svh"

`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fails++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module crp_peak_results_tb;

  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic        aclk;
  logic        aresetn;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        upd_valid, upd_ready;
  crp_pkg::crp_kind_e upd_kind;
  logic [1:0]  upd_pair;
  logic [2:0]  upd_peak;
  logic [7:0]  upd_value;
  int          fails, n_checks, cyc;
  logic [7:0]  pos_m [4][5];
  logic [6:0]  amp_m [4][5];
  logic [9:0]  idx_tab [6] = '{`CRP_IDX_POS_D0_C4, `CRP_IDX_POS_D1_D2, `CRP_IDX_POS_D3_D4,
                               `CRP_IDX_AMP_A0_A1, `CRP_IDX_AMP_A2_A3, `CRP_IDX_AMP_A4_B0};

  crp_peak_results dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .upd_valid(upd_valid), .upd_ready(upd_ready), .upd_kind(upd_kind),
    .upd_pair(upd_pair), .upd_peak(upd_peak), .upd_value(upd_value)
  );

  always #2.5 aclk = ~aclk;

  // ----------------------------------------------------------------------
  // hang guard: a few hundred cycles are expected, the ceiling leaves room
  // ----------------------------------------------------------------------
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      close_out();
    end
  end

  // ----------------------------------------------------------------------
  // tasks; each that drives a signal starts one edge on so no signal is assigned twice at once
  // ----------------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (pos_m[p, k]) pos_m[p][k] = 8'h00;
    foreach (amp_m[p, k]) amp_m[p][k] = 7'h00;
  endtask : do_reset

  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready)
      begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready)
      begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!(aw_ok && w_ok));
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read

  task automatic engine_upd(input logic k, input logic [1:0] p, input logic [2:0] n,
                            input logic [7:0] v);
    @(posedge aclk);
    upd_valid <= 1'b1;
    upd_kind  <= crp_pkg::crp_kind_e'(k);
    upd_pair  <= p;
    upd_peak  <= n;
    upd_value <= v;
    do @(posedge aclk); while (!upd_ready);
    upd_valid <= 1'b0;
  endtask : engine_upd

  // register image from the field model; amplitude words keep bits 15 and 7 clear
  function automatic logic [31:0] exp_word(input int i);
    case (i)
      0: return {16'h0000, pos_m[3][0], pos_m[2][4]};
      1: return {16'h0000, pos_m[3][2], pos_m[3][1]};
      2: return {16'h0000, pos_m[3][4], pos_m[3][3]};
      3: return {16'h0000, 1'b0, amp_m[0][1], 1'b0, amp_m[0][0]};
      4: return {16'h0000, 1'b0, amp_m[0][3], 1'b0, amp_m[0][2]};
      default: return {16'h0000, 1'b0, amp_m[1][0], 1'b0, amp_m[0][4]};
    endcase
  endfunction : exp_word

  task automatic check_bank();
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 6; i++)
    begin
      axi_read({idx_tab[i], 2'b00}, d, r);
      `CHK("bank word", exp_word(i), d)
      `CHK("bank rresp", `CRP_RESP_OKAY, r)
    end
  endtask : check_bank

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  v;
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
    upd_valid = 1'b0;
    upd_kind = crp_pkg::crp_kind_pos;
    {upd_pair, upd_peak, upd_value} = 13'h0000;
    fails = 0;
    n_checks = 0;
    cyc = 0;
    do_reset();
    check_bank();
    // every field of every pair, one update every second cycle; amplitude bit 7 set to prove it is dropped
    for (int p = 0; p < 4; p++)
      for (int k = 0; k < 5; k++)
      begin
        v = {1'b1, p[1:0], k[2:0], 2'h1};
        engine_upd(1'b0, p[1:0], k[2:0], v);
        pos_m[p][k] = v;
        v = {2'h3, p[1:0], k[2:0], 1'b0};
        engine_upd(1'b1, p[1:0], k[2:0], v);
        amp_m[p][k] = v[6:0];
      end
    check_bank();
    // bus writes to result words are answered but change nothing
    for (int i = 0; i < 6; i++)
    begin
      axi_write({idx_tab[i], 2'b00}, 32'hffffffff, r);
      `CHK("ro bresp", `CRP_RESP_OKAY, r)
    end
    check_bank();
    axi_write(12'h000, 32'h00000001, r);
    `CHK("unmapped bresp", `CRP_RESP_SLVERR, r)
    axi_read(12'h000, d, r);
    `CHK("unmapped rresp", `CRP_RESP_SLVERR, r)
    `CHK("unmapped rdata", 32'h00000000, d)
    // hold stalls the engine; status shows the hold and the 40 accepted updates
    axi_write({`CRP_IDX_CTRL, 2'b00}, 32'h00000001, r);
    axi_read({`CRP_IDX_STATUS, 2'b00}, d, r);
    `CHK("status", 32'h00002801, d)
    `CHK("upd_ready held", 1'b0, upd_ready)
    // an update offered while held must wait, then land once hold is cleared
    upd_valid <= 1'b1;
    upd_kind  <= crp_pkg::crp_kind_pos;
    upd_pair  <= `CRP_PAIR_C;
    upd_peak  <= `CRP_PEAK_FIFTH;
    upd_value <= 8'h5a;
    axi_read({`CRP_IDX_POS_D0_C4, 2'b00}, d, r);
    `CHK("held word", exp_word(0), d)
    axi_write({`CRP_IDX_CTRL, 2'b00}, 32'h00000000, r);
    upd_valid <= 1'b0;
    pos_m[2][4] = 8'h5a;
    @(posedge aclk);
    `CHK("upd_ready free", 1'b1, upd_ready)
    axi_read({`CRP_IDX_STATUS, 2'b00}, d, r);
    `CHK("status free", 32'h00002900, d)
    check_bank();
    // a second reset in mid-run clears all fields
    do_reset();
    check_bank();
    close_out();
  end

endmodule : crp_peak_results_tb

//--- crp_pkg.sv
// types shared by the peak result bank
package crp_pkg;

  typedef enum logic {crp_kind_pos, crp_kind_amp} crp_kind_e;

  typedef enum logic {crp_rd_idle, crp_rd_resp} crp_rd_e;

  typedef logic [9:0]  crp_idx_t;
  typedef logic [15:0] crp_word_t;

endpackage : crp_pkg

//--- crp_wr_path.sv
// axi4-lite write channels: joins address and data, returns the response
`timescale 1ns/1ps
`include "crp_defs.svh"

module crp_wr_path (
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // write address and data
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [`CRP_ADDR_W-1:0] awaddr,
  input  wire logic                   wvalid,
  output logic                        wready,
  input  wire logic [`CRP_DATA_W-1:0] wdata,
  input  wire logic [3:0]             wstrb,
  // write response
  output logic                        bvalid,
  input  wire logic                   bready,
  output logic [1:0]                  bresp,
  // joined write toward the register file
  output logic                        wr_fire,
  output logic [`CRP_ADDR_W-1:0]      wr_addr,
  output logic [`CRP_DATA_W-1:0]      wr_data,
  output logic [3:0]                  wr_strb,
  input  wire logic [1:0]             wr_resp
);

  logic aw_full_q;
  logic w_full_q;
  logic bvalid_q;
  logic [1:0] bresp_q;

  // both channels stall while a response is pending: one write at a time
  assign awready = !aw_full_q && !bvalid_q;
  assign wready  = !w_full_q && !bvalid_q;
  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      aw_full_q <= 1'b0;
    else if (wr_fire)
      aw_full_q <= 1'b0;
    else if (awvalid && awready)
      aw_full_q <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wr_addr <= '0;
    else if (awvalid && awready)
      wr_addr <= awaddr;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      w_full_q <= 1'b0;
    else if (wr_fire)
      w_full_q <= 1'b0;
    else if (wvalid && wready)
      w_full_q <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_data <= '0;
      wr_strb <= 4'h0;
    end
    else if (wvalid && wready)
    begin
      wr_data <= wdata;
      wr_strb <= wstrb;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= `CRP_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_resp;
    end
    else if (bready)
      bvalid_q <= 1'b0;
  end

  a_b_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> bvalid && bresp == $past(wr_resp))
    else $error("write response missing after joined write");

endmodule : crp_wr_path
